// *** aog_pkg.sv ***
/*
 * Shared constants, enumerations and packed carriers for the operand
 * address generator.
 * Assumes a 16-bit core with sixteen working registers, byte addressed.
 */
package aog_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DW        = 16;
	localparam int NREG      = 16;
	localparam int RIW       = 4;
	localparam int FAW       = 13;
	localparam int NPATH     = 4;
	localparam int BRANCH_W  = 16;
	localparam int INTDIS_W  = 14;
	localparam int LIT8_W    = 8;

	// ----------------------------------------------------------------
	// Register numbers and reset value
	// ----------------------------------------------------------------
	localparam logic [RIW-1:0] X_PTR_A   = 4'h8;
	localparam logic [RIW-1:0] X_PTR_B   = 4'h9;
	localparam logic [RIW-1:0] Y_PTR_A   = 4'hA;
	localparam logic [RIW-1:0] Y_PTR_B   = 4'hB;
	localparam logic [RIW-1:0] MAC_IDX   = 4'hC;
	localparam logic [DW-1:0]  REG_RST   = 16'h0000;

	// ----------------------------------------------------------------
	// Modification steps
	// ----------------------------------------------------------------
	localparam logic [DW-1:0]  STEP_BYTE = 16'h0001;
	localparam logic [DW-1:0]  STEP_WORD = 16'h0002;
	localparam logic [DW-1:0]  STEP_MAC2 = 16'h0002;
	localparam logic [DW-1:0]  STEP_MAC4 = 16'h0004;
	localparam logic [DW-1:0]  STEP_MAC6 = 16'h0006;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CLS_NOP, CLS_ORD, CLS_MOVE, CLS_ACCUM,
		CLS_MAC, CLS_BRANCH, CLS_INTDIS, CLS_IMPLIED
	} aog_cls_e;

	typedef enum logic [3:0] {
		M_NONE, M_FILE, M_REG, M_IND, M_POSTINC, M_POSTDEC,
		M_PREINC, M_PREDEC, M_INDEX, M_LITOFF, M_LIT8, M_LIT16
	} aog_mode_e;

	typedef enum logic [2:0] {
		MAC_NONE, MAC_IND, MAC_POST2, MAC_POST4, MAC_POST6, MAC_INDEX
	} aog_mac_e;

	typedef enum logic [2:0] {
		OP_NONE, OP_USE, OP_POST, OP_PRE, OP_SUM
	} aog_op_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		aog_cls_e        cls;
		aog_mode_e       src_mode;
		aog_mode_e       dst_mode;
		logic [RIW-1:0]  src_reg;
		logic [RIW-1:0]  dst_reg;
		logic [RIW-1:0]  off_reg;
		logic [FAW-1:0]  file_addr;
		logic [DW-1:0]   lit;
		logic            byte_op;
		aog_mac_e        x_mode;
		logic            x_sel;
		logic            x_dec;
		aog_mac_e        y_mode;
		logic            y_sel;
		logic            y_dec;
	} aog_req_s;

	typedef struct packed {
		aog_op_e         op;
		logic [DW-1:0]   base;
		logic [DW-1:0]   addend;
	} aog_path_s;

	typedef struct packed {
		logic [DW-1:0]   src_ea;
		logic            src_mem;
		logic            src_wreg;
		logic [DW-1:0]   src_data;
		logic [DW-1:0]   dst_ea;
		logic            dst_mem;
		logic            dst_wreg;
		logic [RIW-1:0]  dst_reg;
		logic [DW-1:0]   x_ea;
		logic            x_rd;
		logic [DW-1:0]   y_ea;
		logic            y_rd;
		logic [DW-1:0]   imm;
		logic            imm_vld;
		logic [BRANCH_W-1:0] branch_off;
		logic [INTDIS_W-1:0] intdis_cnt;
		logic            implied;
		logic            illegal;
	} aog_res_s;

endpackage

// *** aog_mod_unit.sv ***
/*
 * One address path: forms the effective address and the modified pointer.
 * Assumes the addend already carries its sign in two's complement.
 */
`timescale 1ns/100ps
module aog_mod_unit
	import aog_pkg::*;
(
	// Path request
	input  wire aog_path_s      path_i,
	// Results
	output logic [DW-1:0]       ea_o,
	output logic [DW-1:0]       ptr_o,
	output logic                ptr_wr_o
);

	logic [DW-1:0] sum;

	assign sum = path_i.base + path_i.addend;

	always_comb begin
		ea_o     = '0;
		ptr_o    = path_i.base;
		ptr_wr_o = 1'b0;
		unique case (path_i.op)
			OP_NONE: begin
			end
			OP_USE: begin
				ea_o = path_i.base;
			end
			OP_POST: begin
				ea_o     = path_i.base;
				ptr_o    = sum;
				ptr_wr_o = 1'b1;
			end
			OP_PRE: begin
				ea_o     = sum;
				ptr_o    = sum;
				ptr_wr_o = 1'b1;
			end
			OP_SUM: begin
				ea_o = sum;
			end
			default: begin
			end
		endcase
	end

endmodule

// *** aog_lit_decode.sv ***
/*
 * Literal field extraction for immediates, branches and interrupt disable.
 * Assumes the decoder places the literal field in the low bits of lit.
 */
`timescale 1ns/100ps
module aog_lit_decode
	import aog_pkg::*;
(
	// Decoded fields
	input  wire aog_cls_e       cls_i,
	input  wire aog_mode_e      mode_i,
	input  wire logic [DW-1:0]  lit_i,
	// Literal values
	output logic [DW-1:0]       imm_o,
	output logic                imm_vld_o,
	output logic [BRANCH_W-1:0] branch_off_o,
	output logic [INTDIS_W-1:0] intdis_cnt_o
);

	always_comb begin
		imm_o        = '0;
		imm_vld_o    = 1'b0;
		branch_off_o = '0;
		intdis_cnt_o = '0;
		if (cls_i == CLS_BRANCH) begin
			branch_off_o = lit_i[BRANCH_W-1:0];
		end
		if (cls_i == CLS_INTDIS) begin
			intdis_cnt_o = lit_i[INTDIS_W-1:0];
		end
		if (mode_i == M_LIT8) begin
			imm_o     = {{(DW-LIT8_W){1'b0}}, lit_i[LIT8_W-1:0]};
			imm_vld_o = 1'b1;
		end else if (mode_i == M_LIT16) begin
			imm_o     = lit_i;
			imm_vld_o = 1'b1;
		end
	end

endmodule

// *** aog_top.sv ***
/*
 * Operand address generator: holds the working registers, turns a decoded
 * instruction into effective addresses for the main, X and Y data paths,
 * and applies pointer pre/post modification.
 * Assumes the decoder presents one request per cycle and the core writes
 * results back through the register write port.
 */
// Summary of operation
// - File direct mode takes the address from the instruction's address field.
// - Register direct mode uses the working register itself, no memory access.
// - Register indirect uses the base pointer value as effective address.
// - Post-modify uses the old pointer, then steps it up or down.
// - Pre-modify adds a signed step first, then uses the new pointer.
// - Indexed address is base pointer plus offset register.
// - Literal offset address is base pointer plus instruction literal.
// - Move source and destination modes differ but share one offset field.
// - Only move and accumulator classes allow indexed and 8/16-bit literals.
// - Multiply-accumulate class uses a reduced set of pointer modes.
// - Multiply-accumulate prefetch pointers are working registers 8 to 11.
// - Pointers 8 and 9 feed X generator, 10 and 11 feed Y.
// - Prefetch indexing allowed only on pointer 9 and pointer 11.
// - Prefetch modes: indirect, indexed, post-modify by 2, 4 or 6.
// - Branch destination is a 16-bit signed literal field.
// - Interrupt disable count is a 14-bit unsigned literal field.
// - Implied-operand instructions generate no address, operand comes from opcode.
// - No-operation has no operands and generates no address.
`timescale 1ns/100ps
module aog_top
	import aog_pkg::*;
(
	// Clock and reset
	input  wire logic           sys_clk_i,
	input  wire logic           rstn_i,
	// Decoded instruction
	input  wire logic           req_valid_i,
	input  wire aog_req_s       req_i,
	output logic                req_ready_o,
	// Core register write-back
	input  wire logic           wr_en_i,
	input  wire logic [RIW-1:0] wr_idx_i,
	input  wire logic [DW-1:0]  wr_data_i,
	// Register inspection
	input  wire logic [RIW-1:0] rd_idx_i,
	output logic [DW-1:0]       rd_data_o,
	// Generated operands
	output logic                res_valid_o,
	output aog_res_s            res_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [DW-1:0] wreg_reg  [NREG];
	logic [DW-1:0] wreg_next [NREG];
	aog_res_s      res_reg;
	aog_res_s      res_next;
	logic          vld_reg;
	logic          vld_next;
	logic [DW-1:0] rd_reg;
	logic [DW-1:0] rd_next;

	// ----------------------------------------------------------------
	// Path helpers
	// ----------------------------------------------------------------
	function automatic aog_path_s gen_path(
		input aog_mode_e     mode,
		input logic [DW-1:0] base,
		input logic [DW-1:0] off,
		input logic [DW-1:0] lit,
		input logic [DW-1:0] step
	);
		aog_path_s p;
		p.op     = OP_NONE;
		p.base   = base;
		p.addend = '0;
		unique case (mode)
			M_IND: begin
				p.op = OP_USE;
			end
			M_POSTINC: begin
				p.op     = OP_POST;
				p.addend = step;
			end
			M_POSTDEC: begin
				p.op     = OP_POST;
				p.addend = -step;
			end
			M_PREINC: begin
				p.op     = OP_PRE;
				p.addend = step;
			end
			M_PREDEC: begin
				p.op     = OP_PRE;
				p.addend = -step;
			end
			M_INDEX: begin
				p.op     = OP_SUM;
				p.addend = off;
			end
			M_LITOFF: begin
				p.op     = OP_SUM;
				p.addend = lit;
			end
			default: begin
				p.op = OP_NONE;
			end
		endcase
		return p;
	endfunction

	function automatic aog_path_s mac_path(
		input aog_mac_e      mode,
		input logic          dec,
		input logic [DW-1:0] base,
		input logic [DW-1:0] idx
	);
		aog_path_s p;
		logic [DW-1:0] st;
		p.op     = OP_NONE;
		p.base   = base;
		p.addend = '0;
		st       = '0;
		unique case (mode)
			MAC_IND: begin
				p.op = OP_USE;
			end
			MAC_POST2: begin
				p.op = OP_POST;
				st   = STEP_MAC2;
			end
			MAC_POST4: begin
				p.op = OP_POST;
				st   = STEP_MAC4;
			end
			MAC_POST6: begin
				p.op = OP_POST;
				st   = STEP_MAC6;
			end
			MAC_INDEX: begin
				p.op     = OP_SUM;
				p.addend = idx;
			end
			default: begin
				p.op = OP_NONE;
			end
		endcase
		if (p.op == OP_POST) begin
			p.addend = dec ? -st : st;
		end
		return p;
	endfunction

	function automatic logic is_mem(input aog_mode_e m);
		return (m == M_IND) || (m == M_POSTINC) || (m == M_POSTDEC) ||
			(m == M_PREINC) || (m == M_PREDEC) || (m == M_INDEX) ||
			(m == M_LITOFF) || (m == M_FILE);
	endfunction

	function automatic logic ext_mode(input aog_mode_e m);
		return (m == M_INDEX) || (m == M_LIT8) || (m == M_LIT16);
	endfunction

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	logic          take;
	logic          ea_cls;
	logic          mac_cls;
	logic          wide_ok;
	logic          bad_mode;
	logic          bad_mac;
	logic          ok;
	logic [DW-1:0] step;
	logic [DW-1:0] off_val;
	logic [RIW-1:0] x_idx;
	logic [RIW-1:0] y_idx;

	assign req_ready_o = 1'b1;
	assign take        = req_valid_i;
	assign ea_cls      = (req_i.cls == CLS_ORD) || (req_i.cls == CLS_MOVE) ||
		(req_i.cls == CLS_ACCUM);
	assign mac_cls     = (req_i.cls == CLS_MAC);
	assign wide_ok     = (req_i.cls == CLS_MOVE) || (req_i.cls == CLS_ACCUM);
	assign bad_mode    = ea_cls && !wide_ok &&
		(ext_mode(req_i.src_mode) || ext_mode(req_i.dst_mode));
	assign bad_mac     = mac_cls &&
		(((req_i.x_mode == MAC_INDEX) && !req_i.x_sel) ||
		((req_i.y_mode == MAC_INDEX) && !req_i.y_sel));
	assign ok          = !bad_mode && !bad_mac;
	assign step        = req_i.byte_op ? STEP_BYTE : STEP_WORD;
	assign off_val     = wreg_reg[req_i.off_reg];
	assign x_idx       = req_i.x_sel ? X_PTR_B : X_PTR_A;
	assign y_idx       = req_i.y_sel ? Y_PTR_B : Y_PTR_A;

	// ----------------------------------------------------------------
	// Address paths: source, destination, X prefetch, Y prefetch
	// ----------------------------------------------------------------
	aog_path_s     path   [NPATH];
	logic [DW-1:0] ea     [NPATH];
	logic [DW-1:0] ptr    [NPATH];
	logic          ptr_wr [NPATH];
	logic [RIW-1:0] pidx  [NPATH];

	always_comb begin
		for (int i = 0; i < NPATH; i++) begin
			path[i] = '0;
		end
		pidx[0] = req_i.src_reg;
		pidx[1] = req_i.dst_reg;
		pidx[2] = x_idx;
		pidx[3] = y_idx;
		if (ea_cls) begin
			path[0] = gen_path(req_i.src_mode, wreg_reg[req_i.src_reg],
				off_val, req_i.lit, step);
			path[1] = gen_path(req_i.dst_mode, wreg_reg[req_i.dst_reg],
				off_val, req_i.lit, step);
		end
		if (mac_cls) begin
			path[2] = mac_path(req_i.x_mode, req_i.x_dec,
				wreg_reg[x_idx], wreg_reg[MAC_IDX]);
			path[3] = mac_path(req_i.y_mode, req_i.y_dec,
				wreg_reg[y_idx], wreg_reg[MAC_IDX]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NPATH; g++) begin : g_path
			aog_mod_unit u_mod (
				.path_i   (path[g]),
				.ea_o     (ea[g]),
				.ptr_o    (ptr[g]),
				.ptr_wr_o (ptr_wr[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Literal fields
	// ----------------------------------------------------------------
	logic [DW-1:0]       imm;
	logic                imm_vld;
	logic [BRANCH_W-1:0] branch_off;
	logic [INTDIS_W-1:0] intdis_cnt;

	aog_lit_decode u_lit (
		.cls_i        (req_i.cls),
		.mode_i       (ea_cls ? req_i.src_mode : M_NONE),
		.lit_i        (req_i.lit),
		.imm_o        (imm),
		.imm_vld_o    (imm_vld),
		.branch_off_o (branch_off),
		.intdis_cnt_o (intdis_cnt)
	);

	// ----------------------------------------------------------------
	// Working registers: pointer updates win over core write-back
	// ----------------------------------------------------------------
	always_comb begin
		for (int r = 0; r < NREG; r++) begin
			wreg_next[r] = wreg_reg[r];
			if (wr_en_i && (wr_idx_i == RIW'(r))) begin
				wreg_next[r] = wr_data_i;
			end
			for (int i = 0; i < NPATH; i++) begin
				if (take && ok && ptr_wr[i] && (pidx[i] == RIW'(r))) begin
					wreg_next[r] = ptr[i];
				end
			end
		end
		rd_next = wreg_reg[rd_idx_i];
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			for (int r = 0; r < NREG; r++) begin
				wreg_reg[r] <= REG_RST;
			end
			rd_reg <= REG_RST;
		end else begin
			for (int r = 0; r < NREG; r++) begin
				wreg_reg[r] <= wreg_next[r];
			end
			rd_reg <= rd_next;
		end
	end

	// ----------------------------------------------------------------
	// Result assembly
	// ----------------------------------------------------------------
	always_comb begin
		res_next = '0;
		vld_next = take;
		if (take) begin
			res_next.illegal = !ok;
			unique case (req_i.cls)
				CLS_NOP: begin
					res_next.illegal = 1'b0;
				end
				CLS_IMPLIED: begin
					res_next.implied = 1'b1;
				end
				CLS_BRANCH: begin
					res_next.branch_off = branch_off;
				end
				CLS_INTDIS: begin
					res_next.intdis_cnt = intdis_cnt;
				end
				CLS_MAC: begin
					if (ok) begin
						res_next.x_ea = ea[2];
						res_next.x_rd = path[2].op != OP_NONE;
						res_next.y_ea = ea[3];
						res_next.y_rd = path[3].op != OP_NONE;
					end
				end
				default: begin
					if (ok) begin
						res_next.src_mem  = is_mem(req_i.src_mode);
						res_next.dst_mem  = is_mem(req_i.dst_mode);
						res_next.src_ea   = ea[0];
						res_next.dst_ea   = ea[1];
						if (req_i.src_mode == M_FILE) begin
							res_next.src_ea = {{(DW-FAW){1'b0}}, req_i.file_addr};
						end
						if (req_i.dst_mode == M_FILE) begin
							res_next.dst_ea = {{(DW-FAW){1'b0}}, req_i.file_addr};
						end
						res_next.src_wreg = req_i.src_mode == M_REG;
						res_next.src_data = wreg_reg[req_i.src_reg];
						res_next.dst_wreg = req_i.dst_mode == M_REG;
						res_next.dst_reg  = req_i.dst_reg;
						res_next.imm      = imm;
						res_next.imm_vld  = imm_vld;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			res_reg <= '0;
			vld_reg <= 1'b0;
		end else begin
			res_reg <= res_next;
			vld_reg <= vld_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign res_o       = res_reg;
	assign res_valid_o = vld_reg;
	assign rd_data_o   = rd_reg;

endmodule

// *** aog_props.sv ***
/*
 * Concurrent checks on the operand address generator result port.
 * Assumes one result per taken request, registered one cycle later.
 */
`timescale 1ns/100ps
module aog_props
	import aog_pkg::*;
(
	// Clock and reset
	input  wire logic     sys_clk_i,
	input  wire logic     rstn_i,
	// Request and result
	input  wire logic     req_valid_i,
	input  wire aog_req_s req_i,
	input  wire aog_res_s res_o
);
	// ----------------------------------------------------------------
	// Request seen at the previous edge
	// ----------------------------------------------------------------
	logic     vld_q;
	aog_req_s req_q;

	always_ff @(posedge sys_clk_i) begin
		vld_q <= rstn_i & req_valid_i;
		req_q <= req_i;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	file_addr_a: assert property (
		vld_q && req_q.cls == CLS_ORD && req_q.src_mode == M_FILE
		|-> res_o.src_mem && res_o.src_ea == 16'(req_q.file_addr))
		else $error("file direct address mismatch");
	reg_direct_a: assert property (
		vld_q && req_q.cls == CLS_ORD && req_q.src_mode == M_REG |-> res_o.src_wreg && !res_o.src_mem)
		else $error("register direct touched memory");
	post_step_a: assert property (
		vld_q && req_q.cls == CLS_ORD && req_q.src_mode == M_POSTINC && req_q.dst_mode == M_NONE
		&& !req_q.byte_op ##1 vld_q && req_q == $past(req_q)
		|-> res_o.src_ea == $past(res_o.src_ea) + STEP_WORD)
		else $error("post increment step wrong");
	ord_illegal_a: assert property (
		vld_q && req_q.cls == CLS_ORD && req_q.src_mode inside {M_INDEX, M_LIT8, M_LIT16}
		|-> res_o.illegal && res_o.src_ea == 16'h0000)
		else $error("ordinary class accepted extended mode");
	lit8_zero_a: assert property (
		vld_q && req_q.cls inside {CLS_MOVE, CLS_ACCUM} && req_q.src_mode == M_LIT8
		|-> res_o.imm_vld && res_o.imm == {8'h00, req_q.lit[7:0]})
		else $error("short literal wrong");
	mac_read_a: assert property (
		vld_q && req_q.cls == CLS_MAC && !res_o.illegal
		|-> res_o.x_rd == (req_q.x_mode != MAC_NONE) && res_o.y_rd == (req_q.y_mode != MAC_NONE))
		else $error("prefetch read flags wrong");
	mac_index_a: assert property (
		vld_q && req_q.cls == CLS_MAC && ((req_q.x_mode == MAC_INDEX && !req_q.x_sel)
		|| (req_q.y_mode == MAC_INDEX && !req_q.y_sel)) |-> res_o.illegal && res_o.x_ea == 16'h0000)
		else $error("prefetch index on wrong pointer");
	branch_lit_a: assert property (
		vld_q && req_q.cls == CLS_BRANCH |-> res_o.branch_off == req_q.lit)
		else $error("branch literal wrong");
	intdis_lit_a: assert property (
		vld_q && req_q.cls == CLS_INTDIS |-> res_o.intdis_cnt == req_q.lit[13:0])
		else $error("disable count wrong");
	implied_op_a: assert property (
		vld_q && req_q.cls == CLS_IMPLIED |-> res_o.implied && !res_o.src_mem && !res_o.dst_mem)
		else $error("implied operand made an address");
	nop_clear_a: assert property (
		vld_q && req_q.cls == CLS_NOP |-> res_o == '0)
		else $error("no-operation produced output");
endmodule

// *** testbench.sv ***
/*
 * Self-checking bench for the operand address generator.
 * Assumes aog_pkg, the design files and aog_props are compiled first.
 */
`timescale 1ns/100ps
module testbench
	import aog_pkg::*;
;
	logic            sys_clk_i;
	logic            rstn_i;
	logic            req_valid_i;
	aog_req_s        req_i;
	logic            req_ready_o;
	logic            wr_en_i;
	logic [RIW-1:0]  wr_idx_i;
	logic [DW-1:0]   wr_data_i;
	logic [RIW-1:0]  rd_idx_i;
	logic [DW-1:0]   rd_data_o;
	logic            res_valid_o;
	aog_res_s        res_o;
	int              errors;
	int              samples_checked;
	aog_req_s        r;

	aog_top uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.req_ready_o(req_ready_o), .wr_en_i(wr_en_i), .wr_idx_i(wr_idx_i), .wr_data_i(wr_data_i),
		.rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o), .res_valid_o(res_valid_o), .res_o(res_o));

	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic step();
		@(posedge sys_clk_i);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic setw(input logic [RIW-1:0] i, input logic [15:0] d);
		wr_en_i   = 1'b1;
		wr_idx_i  = i;
		wr_data_i = d;
		step();
	endtask

	// Valid stays up so that consecutive calls issue back to back
	task automatic send(input aog_req_s q);
		req_valid_i = 1'b1;
		req_i       = q;
		step();
		chk(16'(res_valid_o), 16'h0001, "result valid");
		chk(16'(req_ready_o), 16'h0001, "request ready");
	endtask

	task automatic idle(input string name);
		req_valid_i = 1'b0;
		wr_en_i     = 1'b0;
		step();
		chk(16'(res_o === '0), 16'h0001, "idle result");
		chk(16'(res_valid_o), 16'h0000, "valid after idle");
		$display("test %s done", name);
	endtask

	task automatic rdreg(input logic [RIW-1:0] i, input logic [15:0] exp);
		rd_idx_i = i;
		step();
		chk(rd_data_o, exp, "register value");
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk(16'(res_o === '0), 16'h0001, "result after reset");
		rdreg(4'h5, 16'h0000);
		for (int i = 1; i < 16; i++) begin
			setw(4'(i), (i == 12) ? 16'h0008 : 16'(i << 8));
		end
		idle("reset");
		rdreg(4'hC, 16'h0008);
	endtask

	task automatic t_direct();
		r = '0;
		r.cls = CLS_ORD;
		r.src_mode = M_FILE;
		r.file_addr = 13'h1FFF;
		r.dst_mode = M_REG;
		r.dst_reg = 4'h4;
		send(r);
		chk(res_o.src_ea, 16'h1FFF, "file address");
		chk(16'(res_o.dst_wreg), 16'h0001, "dest register flag");
		chk(16'(res_o.dst_reg), 16'h0004, "dest register index");
		r.src_mode = M_REG;
		r.src_reg = 4'h3;
		r.dst_mode = M_FILE;
		r.file_addr = 13'h0ABC;
		send(r);
		chk(res_o.src_data, 16'h0300, "register operand");
		chk(16'(res_o.src_mem), 16'h0000, "register no memory");
		chk(res_o.dst_ea, 16'h0ABC, "file dest address");
		chk(16'(res_o.dst_mem), 16'h0001, "file dest memory");
		idle("direct");
	endtask

	task automatic t_indirect();
		r = '0;
		r.cls = CLS_ORD;
		r.src_reg = 4'h1;
		r.src_mode = M_IND;
		send(r);
		chk(res_o.src_ea, 16'h0100, "indirect");
		r.src_mode = M_POSTINC;
		send(r);
		chk(res_o.src_ea, 16'h0100, "post inc first");
		send(r);
		chk(res_o.src_ea, 16'h0102, "post inc second");
		r.src_mode = M_POSTDEC;
		r.byte_op = 1'b1;
		send(r);
		chk(res_o.src_ea, 16'h0104, "post dec byte");
		r.src_mode = M_PREDEC;
		r.byte_op = 1'b0;
		send(r);
		chk(res_o.src_ea, 16'h0101, "pre dec word");
		r.src_mode = M_PREINC;
		r.byte_op = 1'b1;
		send(r);
		chk(res_o.src_ea, 16'h0102, "pre inc byte");
		idle("indirect");
		rdreg(4'h1, 16'h0102);
	endtask

	task automatic t_move();
		r = '0;
		r.cls = CLS_MOVE;
		r.src_mode = M_INDEX;
		r.src_reg = 4'h5;
		r.off_reg = 4'h6;
		r.dst_mode = M_LITOFF;
		r.dst_reg = 4'h7;
		r.lit = 16'hFFFC;
		send(r);
		chk(res_o.src_ea, 16'h0B00, "indexed source");
		chk(res_o.dst_ea, 16'h06FC, "literal offset dest");
		r.src_mode = M_IND;
		r.dst_mode = M_INDEX;
		send(r);
		chk(res_o.dst_ea, 16'h0D00, "shared offset on dest");
		chk(res_o.src_ea, 16'h0500, "plain source");
		r.cls = CLS_ACCUM;
		r.src_mode = M_LIT8;
		r.dst_mode = M_NONE;
		r.lit = 16'h12AB;
		send(r);
		chk(res_o.imm, 16'h00AB, "short literal");
		r.cls = CLS_MOVE;
		r.src_mode = M_LIT16;
		r.lit = 16'h8001;
		send(r);
		chk(res_o.imm, 16'h8001, "long literal");
		r.cls = CLS_ORD;
		r.src_mode = M_INDEX;
		send(r);
		chk(16'(res_o.illegal), 16'h0001, "ordinary indexed refused");
		chk(res_o.src_ea, 16'h0000, "refused address");
		r.src_mode = M_LIT16;
		send(r);
		chk(16'(res_o.illegal), 16'h0001, "ordinary literal refused");
		idle("move");
		rdreg(4'h5, 16'h0500);
	endtask

	task automatic t_mac();
		r = '0;
		r.cls = CLS_MAC;
		r.x_mode = MAC_POST4;
		r.y_mode = MAC_POST6;
		r.y_sel = 1'b1;
		r.y_dec = 1'b1;
		// X post-modifies pointer 8 up by 4 and Y post-modifies pointer 11 down by 6; both are checked before and after stepping
		send(r);
		chk(res_o.x_ea, 16'h0800, "x first pointer");
		chk(res_o.y_ea, 16'h0B00, "y second pointer");
		send(r);
		chk(res_o.x_ea, 16'h0804, "x post by 4");
		chk(res_o.y_ea, 16'h0AFA, "y post by minus 6");
		r.x_mode = MAC_INDEX;
		r.x_sel = 1'b1;
		r.y_mode = MAC_POST2;
		r.y_sel = 1'b0;
		r.y_dec = 1'b0;
		send(r);
		chk(res_o.x_ea, 16'h0908, "x indexed");
		chk(res_o.y_ea, 16'h0A00, "y post by 2");
		r.x_mode = MAC_IND;
		r.x_sel = 1'b0;
		r.y_mode = MAC_INDEX;
		r.y_sel = 1'b1;
		send(r);
		chk(res_o.x_ea, 16'h0808, "x indirect");
		chk(res_o.y_ea, 16'h0AFC, "y indexed");
		r.x_mode = MAC_INDEX;
		r.y_mode = MAC_NONE;
		send(r);
		chk(16'(res_o.illegal), 16'h0001, "index on first pointer");
		r.x_mode = MAC_NONE;
		r.y_mode = MAC_IND;
		r.y_sel = 1'b0;
		send(r);
		chk(16'(res_o.x_rd), 16'h0000, "no x read");
		chk(res_o.y_ea, 16'h0A02, "y indirect");
		idle("mac");
		rdreg(4'h8, 16'h0808);
		rdreg(4'hB, 16'h0AF4);
	endtask

	task automatic t_other();
		r = '0;
		r.cls = CLS_BRANCH;
		r.lit = 16'h8000;
		send(r);
		chk(res_o.branch_off, 16'h8000, "branch literal");
		r.cls = CLS_INTDIS;
		r.lit = 16'hFFFF;
		send(r);
		chk(16'(res_o.intdis_cnt), 16'h3FFF, "disable count");
		r.cls = CLS_IMPLIED;
		send(r);
		chk(16'(res_o.implied), 16'h0001, "implied flag");
		r.cls = CLS_NOP;
		r.src_mode = M_FILE;
		r.file_addr = 13'h1234;
		send(r);
		chk(16'(res_o === '0), 16'h0001, "no-operation result");
		idle("other");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		rstn_i          = 1'b0;
		req_valid_i     = 1'b0;
		req_i           = '0;
		wr_en_i         = 1'b0;
		wr_idx_i        = '0;
		wr_data_i       = '0;
		rd_idx_i        = '0;
		errors          = 0;
		samples_checked = 0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		rstn_i = 1'b1;
		t_reset();
		t_direct();
		t_indirect();
		t_move();
		t_mac();
		t_other();
		print_verdict();
	end

	initial begin
		repeat (2000) @(posedge sys_clk_i);
		errors++;
		print_verdict();
	end
endmodule

bind aog_top aog_props u_props (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
	.req_i(req_i), .res_o(res_o));
